// File: modem_tx_map.svh
// Operation
// - Latch switch bank only at power-up
// - Auto mode: transmit data activity raises request
// - Auto mode: forward data after training ends
// - Auto mode: drop transmitter after idle period
// - Bell switched carrier: 10 or 33 ms
// - V.23 mode: fixed 33 ms delay
// - Constant carrier: on except while inhibited or locked out, fast clear-to-send
// - Switched carrier: request keys carrier, delayed
// - Bell soft carrier: turn-off tone ends transmission
// - Anti-streaming: cut transmitter after 30 s
// - After cutoff wait for request on-to-off
// - Duplex switch: off four-wire, on two-wire
// - Switched termination: 600 ohm only during request
// - Receiver termination switch selects 600 or high
// - Closed switch is on; defaults off except receiver
`ifndef MODEM_TX_MAP_SVH
`define MODEM_TX_MAP_SVH

`define CLK_KHZ            100000
`define CLK_HZ             100000000
`define SHORT_DELAY_MS     10
`define LONG_DELAY_MS      33
`define CONST_CTS_US       500
`define STREAM_LIMIT_S     30
`define IDLE_LIMIT_MS      20
`define SOFT_TONE_MS       10
`define BOOT_SETTLE        4'h4
`define CFG_RESET          8'h80
`define PIN_TXD            0
`define PIN_RTS            1
`define PIN_SW_LO          2
`define PIN_SW_HI          9
`define PIN_V23            10
`define PIN_W              11
`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define CTRL_INHIBIT       0

`endif

// File: modem_tx_pkg.sv
package modem_tx_pkg;

	typedef enum logic [2:0] {
		PH_IDLE    = 3'b000,
		PH_DELAY   = 3'b001,
		PH_SEND    = 3'b010,
		PH_SOFT    = 3'b011,
		PH_LOCKOUT = 3'b100
	} phase_t;

	// Bit order follows the switch bank, position 1 in bit 0
	typedef struct packed {
		logic rx_termination_select;
		logic tx_termination_switch_select;
		logic line_duplex_select;
		logic transmit_timeout_select;
		logic soft_turnoff_select;
		logic constant_carrier_select;
		logic handshake_delay_select;
		logic auto_request_select;
	} cfg_t;

	typedef struct packed {
		logic cts;
		logic carrier_on;
		logic soft_tone;
		logic data_gate;
		logic half_duplex;
		logic tx_term_600;
		logic rx_term_600;
	} line_ctl_t;

	typedef struct packed {
		logic [10:0] s1;
		logic [10:0] s2;
		logic [10:0] s3;
		logic [10:0] filt;
		logic [3:0]  boot_cnt;
		logic        cfg_done;
		cfg_t        cfg;
		logic        v23;
		phase_t      phase;
		logic [31:0] tmr;
		logic [31:0] stream_cnt;
		logic [31:0] idle_cnt;
		logic        auto_rts;
		logic        rts_prev;
		logic        txd_prev;
		logic        tx_inhibit;
		line_ctl_t   line;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} core_t;

endpackage

// File: modem_tx_ctl.sv
`timescale 1ns/100ps
`default_nettype none
`include "modem_tx_map.svh"

module modem_tx_ctl #(
	parameter logic [31:0] SHORT_CYCLES  = 32'(`SHORT_DELAY_MS * `CLK_KHZ),
	parameter logic [31:0] LONG_CYCLES   = 32'(`LONG_DELAY_MS * `CLK_KHZ),
	parameter logic [31:0] CONST_LIMIT   = 32'(`CONST_CTS_US * (`CLK_KHZ / 1000)),
	parameter logic [31:0] STREAM_CYCLES = 32'(64'(`STREAM_LIMIT_S) * 64'(`CLK_HZ)),
	parameter logic [31:0] IDLE_CYCLES   = 32'(`IDLE_LIMIT_MS * `CLK_KHZ),
	parameter logic [31:0] SOFT_CYCLES   = 32'(`SOFT_TONE_MS * `CLK_KHZ)
) (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic [7:0]              config_switch_bank,
	input  wire logic                    v23_strap,
	input  wire logic                    rts_in,
	input  wire logic                    txd_in,
	output var  modem_tx_pkg::line_ctl_t line_ctl,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr
);

	generate
		if (SHORT_CYCLES == 32'h0 || LONG_CYCLES == 32'h0 || STREAM_CYCLES == 32'h0 ||
			IDLE_CYCLES == 32'h0 || SOFT_CYCLES == 32'h0 || CONST_LIMIT < 32'h3) begin : g_bad
			$error("modem_tx_ctl: timing parameters out of range");
		end
	endgenerate

	modem_tx_pkg::core_t q_ff;
	modem_tx_pkg::core_t nxt_q;
	logic                rts_eff;
	logic                activity;
	logic                rts_fall;
	logic                soft_ok;
	logic [31:0]         dly;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		nxt_q = q_ff;

		// Three-stage pin capture, value moves when stages 2 and 3 agree
		nxt_q.s1 = {v23_strap, config_switch_bank, rts_in, txd_in};
		nxt_q.s2 = q_ff.s1;
		nxt_q.s3 = q_ff.s2;
		nxt_q.filt = (q_ff.s2 & q_ff.s3) | (q_ff.filt & (q_ff.s2 ^ q_ff.s3));

		// Switch bank sampled once after reset settles, never again
		if (!q_ff.cfg_done) begin
			nxt_q.boot_cnt = q_ff.boot_cnt + 4'h1;
			if (q_ff.boot_cnt == `BOOT_SETTLE) begin
				nxt_q.cfg_done = 1'b1;
				nxt_q.cfg = modem_tx_pkg::cfg_t'(q_ff.filt[`PIN_SW_HI:`PIN_SW_LO]);
				nxt_q.v23 = q_ff.filt[`PIN_V23];
			end
		end

		// Any edge on transmit data counts as activity
		activity = q_ff.cfg_done && (q_ff.filt[`PIN_TXD] != q_ff.txd_prev);
		nxt_q.txd_prev = q_ff.filt[`PIN_TXD];

		// Internal request for terminals without a request line
		if (q_ff.cfg.auto_request_select && q_ff.cfg_done) begin
			if (activity) begin
				nxt_q.auto_rts = 1'b1;
				nxt_q.idle_cnt = 32'h0;
			end else if (q_ff.auto_rts) begin
				if (q_ff.idle_cnt >= IDLE_CYCLES - 32'h1) begin
					nxt_q.auto_rts = 1'b0;
					nxt_q.idle_cnt = 32'h0;
				end else begin
					nxt_q.idle_cnt = q_ff.idle_cnt + 32'h1;
				end
			end
		end else begin
			nxt_q.auto_rts = 1'b0;
			nxt_q.idle_cnt = 32'h0;
		end

		rts_eff = q_ff.cfg_done && !q_ff.tx_inhibit && (q_ff.filt[`PIN_RTS] || q_ff.auto_rts);
		nxt_q.rts_prev = rts_eff;
		rts_fall = q_ff.rts_prev && !rts_eff;

		// V.23 ignores the delay switch
		if (q_ff.v23 || q_ff.cfg.handshake_delay_select) begin
			dly = LONG_CYCLES;
		end else begin
			dly = SHORT_CYCLES;
		end

		soft_ok = !q_ff.v23 && q_ff.cfg.soft_turnoff_select && !q_ff.cfg.constant_carrier_select;

		case (q_ff.phase)
			modem_tx_pkg::PH_IDLE: begin
				nxt_q.tmr = 32'h0;
				nxt_q.stream_cnt = 32'h0;
				if (rts_eff) begin
					if (q_ff.cfg.constant_carrier_select) begin
						nxt_q.phase = modem_tx_pkg::PH_SEND;
					end else begin
						nxt_q.phase = modem_tx_pkg::PH_DELAY;
					end
				end
			end
			modem_tx_pkg::PH_DELAY: begin
				if (!rts_eff) begin
					nxt_q.phase = modem_tx_pkg::PH_IDLE;
				end else if (q_ff.tmr >= dly - 32'h1) begin
					nxt_q.phase = modem_tx_pkg::PH_SEND;
					nxt_q.stream_cnt = 32'h0;
				end else begin
					nxt_q.tmr = q_ff.tmr + 32'h1;
				end
			end
			modem_tx_pkg::PH_SEND: begin
				nxt_q.tmr = 32'h0;
				if (!rts_eff) begin
					if (soft_ok) begin
						nxt_q.phase = modem_tx_pkg::PH_SOFT;
					end else begin
						nxt_q.phase = modem_tx_pkg::PH_IDLE;
					end
				end else if (q_ff.cfg.transmit_timeout_select &&
					q_ff.stream_cnt >= STREAM_CYCLES - 32'h1) begin
					nxt_q.phase = modem_tx_pkg::PH_LOCKOUT;
				end else begin
					nxt_q.stream_cnt = q_ff.stream_cnt + 32'h1;
				end
			end
			modem_tx_pkg::PH_SOFT: begin
				if (q_ff.tmr >= SOFT_CYCLES - 32'h1) begin
					nxt_q.phase = modem_tx_pkg::PH_IDLE;
					nxt_q.tmr = 32'h0;
				end else begin
					nxt_q.tmr = q_ff.tmr + 32'h1;
				end
			end
			modem_tx_pkg::PH_LOCKOUT: begin
				if (rts_fall) begin
					nxt_q.phase = modem_tx_pkg::PH_IDLE;
				end
			end
			default: begin
				nxt_q.phase = modem_tx_pkg::PH_IDLE;
			end
		endcase

		// Clear-to-send, data gate and tone follow the next phase so they track it exactly
		nxt_q.line.cts = (nxt_q.phase == modem_tx_pkg::PH_SEND);
		nxt_q.line.data_gate = (nxt_q.phase == modem_tx_pkg::PH_SEND);
		nxt_q.line.soft_tone = (nxt_q.phase == modem_tx_pkg::PH_SOFT);
		nxt_q.line.carrier_on = (nxt_q.phase == modem_tx_pkg::PH_DELAY) ||
			(nxt_q.phase == modem_tx_pkg::PH_SEND) || (nxt_q.phase == modem_tx_pkg::PH_SOFT) ||
			(q_ff.cfg_done && q_ff.cfg.constant_carrier_select && !q_ff.tx_inhibit &&
			nxt_q.phase != modem_tx_pkg::PH_LOCKOUT);
		nxt_q.line.half_duplex = q_ff.cfg.line_duplex_select;
		if (q_ff.cfg.tx_termination_switch_select) begin
			nxt_q.line.tx_term_600 = rts_eff;
		end else begin
			nxt_q.line.tx_term_600 = 1'b1;
		end
		nxt_q.line.rx_term_600 = q_ff.cfg.rx_termination_select;

		// APB slave, answers in the first access cycle
		nxt_q.pready = psel && !penable;
		nxt_q.pslverr = 1'b0;
		if (psel && !penable) begin
			if (paddr == `REG_CTRL) begin
				nxt_q.prdata = {31'h0, q_ff.tx_inhibit};
			end else if (paddr == `REG_STATUS) begin
				nxt_q.prdata = {16'h0, q_ff.phase == modem_tx_pkg::PH_LOCKOUT, q_ff.rts_prev,
					q_ff.auto_rts, q_ff.phase, q_ff.cfg_done, q_ff.v23, q_ff.cfg};
			end else begin
				nxt_q.prdata = 32'h0;
				nxt_q.pslverr = 1'b1;
			end
		end
		if (psel && penable && q_ff.pready && pwrite && paddr == `REG_CTRL) begin
			nxt_q.tx_inhibit = pwdata[`CTRL_INHIBIT];
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q_ff <= '{
				s1: 11'h0, s2: 11'h0, s3: 11'h0, filt: 11'h0,
				boot_cnt: 4'h0, cfg_done: 1'b0,
				cfg: modem_tx_pkg::cfg_t'(`CFG_RESET), v23: 1'b0,
				phase: modem_tx_pkg::PH_IDLE,
				tmr: 32'h0, stream_cnt: 32'h0, idle_cnt: 32'h0,
				auto_rts: 1'b0, rts_prev: 1'b0, txd_prev: 1'b0, tx_inhibit: 1'b0,
				line: '{cts: 1'b0, carrier_on: 1'b0, soft_tone: 1'b0, data_gate: 1'b0,
					half_duplex: 1'b0, tx_term_600: 1'b1, rx_term_600: 1'b1},
				pready: 1'b0, pslverr: 1'b0, prdata: 32'h0
			};
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign line_ctl = q_ff.line;
	assign prdata   = q_ff.prdata;
	assign pready   = q_ff.pready;
	assign pslverr  = q_ff.pslverr;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_cfg_frozen: assert property (q_ff.cfg_done && $past(q_ff.cfg_done) |-> $stable(q_ff.cfg))
		else $error("switch configuration changed after power-up");

	chk_auto_raise: assert property (
		q_ff.cfg.auto_request_select && activity |=> q_ff.auto_rts && q_ff.idle_cnt == 32'h0)
		else $error("activity did not raise internal request");

	chk_gate_train: assert property (
		$rose(line_ctl.data_gate) && !q_ff.cfg.constant_carrier_select
		|-> $past(q_ff.phase) == modem_tx_pkg::PH_DELAY && $past(q_ff.tmr) == $past(dly) - 32'h1)
		else $error("data forwarded before training ended");

	chk_idle_drop: assert property (
		q_ff.auto_rts && !activity && q_ff.cfg.auto_request_select &&
		q_ff.idle_cnt == IDLE_CYCLES - 32'h1 |=> !q_ff.auto_rts)
		else $error("internal request not dropped after idle period");

	chk_cts_delay: assert property (
		$rose(line_ctl.cts) && !q_ff.cfg.constant_carrier_select
		|-> $past(q_ff.tmr) == ((q_ff.v23 || q_ff.cfg.handshake_delay_select) ? LONG_CYCLES : SHORT_CYCLES) - 32'h1)
		else $error("wrong handshake delay selected");

	chk_const_fast: assert property (
		q_ff.cfg.constant_carrier_select && q_ff.phase == modem_tx_pkg::PH_IDLE && rts_eff
		|=> line_ctl.cts && line_ctl.carrier_on)
		else $error("constant carrier slow clear-to-send");

	chk_keyed_carrier: assert property (
		!q_ff.cfg.constant_carrier_select && q_ff.phase == modem_tx_pkg::PH_IDLE && rts_eff
		|=> line_ctl.carrier_on && !line_ctl.cts ##1 !line_ctl.cts || !line_ctl.carrier_on)
		else $error("switched carrier keyed wrongly");

	chk_soft_tone: assert property (
		q_ff.phase == modem_tx_pkg::PH_SEND && !rts_eff && soft_ok
		|=> line_ctl.soft_tone && line_ctl.carrier_on && !line_ctl.cts)
		else $error("turn-off tone missing");

	chk_stream_cut: assert property (
		q_ff.phase == modem_tx_pkg::PH_SEND && rts_eff && q_ff.cfg.transmit_timeout_select &&
		q_ff.stream_cnt == STREAM_CYCLES - 32'h1 |=> !line_ctl.carrier_on && !line_ctl.cts)
		else $error("anti-streaming cutoff missed");

	chk_lock_hold: assert property (
		q_ff.phase == modem_tx_pkg::PH_LOCKOUT && !rts_fall |=> q_ff.phase == modem_tx_pkg::PH_LOCKOUT)
		else $error("lockout left without request falling");

	chk_duplex_pin: assert property (q_ff.cfg_done |=> line_ctl.half_duplex == $past(q_ff.cfg.line_duplex_select))
		else $error("duplex output disagrees with switch");

	chk_tx_term: assert property (
		q_ff.cfg_done |=> line_ctl.tx_term_600 ==
		($past(q_ff.cfg.tx_termination_switch_select) ? $past(rts_eff) : 1'b1))
		else $error("transmit termination wrong");

	chk_rx_default: assert property (!q_ff.cfg_done |-> line_ctl.rx_term_600 && !line_ctl.half_duplex)
		else $error("defaults wrong before configuration");

	chk_cts_drop: assert property (line_ctl.cts && !rts_eff |=> !line_ctl.cts)
		else $error("clear-to-send held after request removed");

	cov_switched: cover property ($rose(line_ctl.cts) && !q_ff.cfg.constant_carrier_select);
	cov_soft: cover property ($rose(line_ctl.soft_tone));
	cov_lockout: cover property (q_ff.phase == modem_tx_pkg::PH_LOCKOUT ##1 rts_fall);
	cov_auto: cover property ($fell(q_ff.auto_rts));

endmodule
`default_nettype wire

// File: modem_dte_model.sv
`timescale 1ns/100ps
`default_nettype none

module modem_dte_model (
	input  wire logic clk,
	input  wire logic rts_req,
	input  wire logic send,
	output var  logic rts_in,
	output var  logic txd_in
);
	logic [1:0] div_ff;

	initial begin
		rts_in = 1'b0;
		txd_in = 1'b1;
		div_ff = 2'h0;
	end

	// --------------------------------
	// Terminal side: request and data
	// --------------------------------
	// Idle data line rests at mark, toggles while sending
	always @(posedge clk) begin
		rts_in <= rts_req;
		div_ff <= div_ff + 2'h1;
		if (!send)
			txd_in <= 1'b1;
		else if (div_ff == 2'h3)
			txd_in <= ~txd_in;
	end
endmodule

`default_nettype wire

// File: modem_tx_ctl_tb.sv
`timescale 1ns/100ps
`default_nettype none

module modem_tx_ctl_tb;
	localparam int SHORT = 40;
	localparam int LONG  = 90;

	logic                    clk;
	logic                    rst;
	logic [7:0]              sw;
	logic                    v23;
	logic                    rts_req;
	logic                    send;
	logic                    rts_in;
	logic                    txd_in;
	modem_tx_pkg::line_ctl_t line_ctl;
	logic                    psel;
	logic                    penable;
	logic                    pwrite;
	logic [7:0]              paddr;
	logic [31:0]             pwdata;
	logic [31:0]             prdata;
	logic                    pready;
	logic                    pslverr;
	logic [31:0]             q;
	logic                    e;
	int                      n;
	int                      n_errors;
	int                      n_tests;

	modem_tx_ctl #(
		.SHORT_CYCLES (32'(SHORT)),
		.LONG_CYCLES  (32'(LONG)),
		.STREAM_CYCLES(32'd300),
		.IDLE_CYCLES  (32'd50),
		.SOFT_CYCLES  (32'd20)
	) modem_tx_ctl_i (
		.clk(clk), .rst(rst), .config_switch_bank(sw), .v23_strap(v23), .rts_in(rts_in), .txd_in(txd_in),
		.line_ctl(line_ctl), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr)
	);

	modem_dte_model modem_dte_model_i (
		.clk(clk), .rts_req(rts_req), .send(send), .rts_in(rts_in), .txd_in(txd_in)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// --------------------------------
	// Shared tasks
	// --------------------------------
	task automatic summarize();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Power cycle: switches latched only after release
	task automatic boot(input logic [7:0] c, input logic v);
		rst     <= 1'b1;
		sw      <= c;
		v23     <= v;
		rts_req <= 1'b0;
		send    <= 1'b0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (12) @(posedge clk);
	endtask

	task automatic wait_bit(input int b, input logic v, input int lim, output int cnt);
		n_tests++;
		for (cnt = 0; cnt < lim; cnt++) begin
			@(posedge clk);
			if (line_ctl[b] === v)
				return;
		end
		n_errors++;
		$display("unexpected at %0t seen %h expected %h", $time, ~v, v);
		summarize();
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20) begin
			n_errors++;
			summarize();
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// Request to clear-to-send, twice, with drop in between
	task automatic delay_case(input logic [7:0] c, input logic v, input int exp);
		boot(c, v);
		repeat (2) begin
			rts_req <= 1'b1;
			wait_bit(6, 1'b1, 200, n);
			chk(32'(n >= exp && n <= exp + 10), 32'h1);
			rts_req <= 1'b0;
			wait_bit(6, 1'b0, 8, n);
			repeat (10) @(posedge clk);
		end
	endtask

	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		rst = 1'b1;
		sw = 8'h80;
		v23 = 1'b0;
		rts_req = 1'b0;
		send = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_errors = 0;
		n_tests = 0;
		boot(8'h80, 1'b0);
		chk(32'(line_ctl), 32'h03);
		sw <= 8'h7f;
		repeat (20) @(posedge clk);
		apb(1'b0, 8'h04, 32'h0);
		chk(q & 32'hff, 32'h80);
		chk(32'(line_ctl), 32'h03);
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b0, 8'h00, 32'h0);
		chk(q, 32'h1);
		rts_req <= 1'b1;
		repeat (80) @(posedge clk);
		chk(32'(line_ctl.cts), 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk({q[30:0], e}, 32'h1);
		delay_case(8'h80, 1'b0, SHORT);
		delay_case(8'h82, 1'b0, LONG);
		delay_case(8'h80, 1'b1, LONG);
		delay_case(8'h82, 1'b1, LONG);
		boot(8'h84, 1'b0);
		chk(32'(line_ctl.carrier_on), 32'h1);
		rts_req <= 1'b1;
		wait_bit(6, 1'b1, 10, n);
		boot(8'h88, 1'b0);
		rts_req <= 1'b1;
		wait_bit(5, 1'b1, 10, n);
		chk(32'(line_ctl.cts), 32'h0);
		wait_bit(6, 1'b1, 60, n);
		rts_req <= 1'b0;
		wait_bit(4, 1'b1, 10, n);
		wait_bit(5, 1'b0, 40, n);
		boot(8'h90, 1'b0);
		rts_req <= 1'b1;
		wait_bit(6, 1'b1, 60, n);
		wait_bit(6, 1'b0, 330, n);
		repeat (60) @(posedge clk);
		chk(32'(line_ctl.carrier_on), 32'h0);
		rts_req <= 1'b0;
		repeat (10) @(posedge clk);
		rts_req <= 1'b1;
		wait_bit(6, 1'b1, 60, n);
		boot(8'h81, 1'b0);
		send <= 1'b1;
		wait_bit(5, 1'b1, 20, n);
		chk(32'(line_ctl.data_gate), 32'h0);
		wait_bit(3, 1'b1, 60, n);
		send <= 1'b0;
		wait_bit(5, 1'b0, 70, n);
		boot(8'h60, 1'b0);
		chk(32'(line_ctl), 32'h04);
		rts_req <= 1'b1;
		wait_bit(1, 1'b1, 10, n);
		chk(32'(line_ctl.rx_term_600), 32'h0);
		summarize();
	end
endmodule

`default_nettype wire
